// >>> pkg/tgb_pkg.sv
package tgb_pkg;

    // Timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned FRAME_HZ     = 8000;
    localparam int unsigned FRAME_CYC    = CLK_HZ / FRAME_HZ;
    localparam int unsigned FRAME_W      = 12;
    localparam logic [11:0] FRAME_LAST   = 12'(FRAME_CYC - 1);
    localparam int unsigned RING_SLOW_HZ = 5;
    localparam int unsigned RING_FAST_HZ = 10;
    localparam logic [9:0]  RING_HALF_SLOW = 10'(FRAME_HZ / (2 * RING_SLOW_HZ) - 1);
    localparam logic [9:0]  RING_HALF_FAST = 10'(FRAME_HZ / (2 * RING_FAST_HZ) - 1);

    // Tone locations and block addresses
    localparam int unsigned N_LOC     = 32;
    localparam int unsigned N_PROG    = 7;
    localparam int unsigned N_FIXED   = 9;
    localparam logic [4:0]  ADDR_FIXED = 5'h10;
    localparam logic [4:0]  ADDR_PROG  = 5'h19;
    localparam logic [4:0]  ADDR_LAST  = 5'h1F;

    // Register map
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STAT = 6'h01;
    localparam logic [5:0] REG_LOW  = 6'h08;
    localparam logic [5:0] REG_HIGH = 6'h10;

    // Control bits
    localparam int unsigned CB_EN    = 0;
    localparam int unsigned CB_RING1 = 1;
    localparam int unsigned CB_RING2 = 2;
    localparam int unsigned CB_RATE  = 3;
    localparam int unsigned CB_ALAW  = 4;
    localparam int unsigned CB_FSK   = 5;
    localparam logic [7:0]  CTRL_RST = 8'h00;

    // Status bits
    localparam int unsigned SB_BUSY = 0;
    localparam int unsigned SB_OVR  = 1;
    localparam int unsigned SB_FULL = 2;

    // Companding
    localparam logic [7:0]  SIL_MU  = 8'hFF;
    localparam logic [7:0]  SIL_A   = 8'hD5;
    localparam logic [7:0]  A_XOR   = 8'h55;
    localparam logic [13:0] MU_BIAS = 14'h0021;

    // Peak amplitudes, linear 14-bit scale
    localparam logic [11:0] AMP_HI_MU = 12'h0B08;
    localparam logic [11:0] AMP_LO_MU = 12'h08C3;
    localparam logic [11:0] AMP_HI_A  = 12'h0584;
    localparam logic [11:0] AMP_LO_A  = 12'h0462;

    // Coefficient to phase step
    localparam logic [7:0]  COEF_MID  = 8'h40;
    localparam logic [7:0]  COEF_TOP  = 8'h80;
    localparam logic [15:0] INC_OFS_LO = 16'h0800;
    localparam logic [15:0] INC_OFS_HI = 16'h2000;

    localparam logic [3:0][7:0] DTMF_ROW = {8'h78, 8'h6D, 8'h62, 8'h59};
    localparam logic [3:0][7:0] DTMF_COL = {8'hA9, 8'h9F, 8'h96, 8'h8D};
    localparam logic [8:0][7:0] FIX_LO = {8'h9A, 8'h2D, 8'h26, 8'h26, 8'h3B,
                                          8'h31, 8'h31, 8'h31, 8'h1A};
    localparam logic [8:0][7:0] FIX_HI = {8'h00, 8'h00, 8'h33, 8'h00, 8'h4F,
                                          8'h4F, 8'h3B, 8'h00, 8'h31};

    // Quarter sine, 16 points, peak 1022
    localparam logic [15:0][9:0] SINE_Q = {
        10'h3FE, 10'h3F4, 10'h3E0, 10'h3C3, 10'h39D, 10'h36D, 10'h336, 10'h2F6,
        10'h2AF, 10'h261, 10'h20E, 10'h1B5, 10'h159, 10'h0F9, 10'h096, 10'h032};

    localparam int unsigned FIFO_DEPTH = 16;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] code;
    } tgb_smp_s;

endpackage : tgb_pkg

// >>> verilog/tgb_tone_bank.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps

module tgb_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         clk,       // System clock
    input  wire logic         srst,      // Sync reset
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Space free
    input  wire logic [W-1:0] in_data,   // Write word
    output logic              out_valid, // Word available
    input  wire logic         out_ready, // Read accept
    output logic [W-1:0]      out_data   // Head word
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } tgb_fifo_st_s;

    tgb_fifo_st_s q;
    tgb_fifo_st_s d;
    logic         wr;
    logic         rd;

    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];

    always_comb begin
        d  = q;
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        if (wr) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (rd) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : tgb_fifo

module tgb_tone_bank
    import tgb_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic       clk,        // 20 MHz system clock
    input  wire logic       srst,       // Sync reset, active high
    input  wire logic [5:0] reg_addr,   // Register address
    input  wire logic [7:0] reg_wdata,  // Register write data
    input  wire logic       reg_wr,     // Write strobe
    input  wire logic       reg_rd,     // Read strobe
    output logic      [7:0] reg_rdata,  // Read data, cycle after strobe
    input  wire logic [7:0] fsk_sample, // FSK modulator PCM code
    output logic            dm_valid,   // Data memory write request
    input  wire logic       dm_ready,   // Data memory accepts
    output tgb_smp_s        dm_word     // Tone block address and code
);
    typedef struct packed {
        logic [7:0]                   ctrl;
        logic [N_PROG-1:0][7:0]       lo;
        logic [N_PROG-1:0][7:0]       hi;
        logic [7:0]                   rdata;
        logic [FRAME_W-1:0]           frame;
        logic                         busy;
        logic [4:0]                   idx;
        logic                         overrun;
        logic [2*N_LOC-1:0][15:0]     phase;
        logic [1:0][7:0]              ring_cnt;
        logic [9:0]                   ring_div;
        logic                         ring_sel;
        logic                         dm_v;
        tgb_smp_s                     dm;
    } tgb_top_st_s;

    tgb_top_st_s       q;
    tgb_top_st_s       d;
    logic              fin_ready;
    logic              fout_valid;
    logic              fout_ready;
    tgb_smp_s          fout_data;
    tgb_smp_s          smp;
    logic              push;
    logic              start;
    logic              en;
    logic              alaw;
    logic              ring_on;
    logic [7:0]        clo;
    logic [7:0]        chi;
    logic [7:0]        crg;
    logic [7:0]        half;
    logic [2:0]        pi;
    logic [11:0]       amp_lo;
    logic [11:0]       amp_hi;
    logic signed [23:0] p_lo;
    logic signed [23:0] p_hi;
    logic signed [24:0] acc;
    logic signed [14:0] lin;
    logic [7:0]        sil;
    logic [9:0]        ring_top;

    function automatic logic [15:0] tgb_inc(input logic [7:0] c);
        if (c == 8'h00) begin
            return 16'h0000;
        end else if (c < COEF_MID) begin
            return INC_OFS_LO + {3'b000, c, 5'b00000};
        end else if (c < COEF_TOP) begin
            return {2'b00, c, 6'b000000};
        end else begin
            return {1'b0, c, 7'b0000000} - INC_OFS_HI;
        end
    endfunction : tgb_inc

    function automatic logic signed [10:0] tgb_sin(input logic [15:0] ph);
        logic [3:0]         k;
        logic signed [10:0] v;
        k = ph[14] ? ~ph[13:10] : ph[13:10];
        v = signed'({1'b0, SINE_Q[k]});
        return ph[15] ? -v : v;
    endfunction : tgb_sin

    function automatic logic [7:0] tgb_mu(input logic signed [14:0] s);
        logic       neg;
        logic [13:0] m;
        logic [2:0] seg;
        neg = s[14];
        m   = neg ? 14'(-s) : 14'(s);
        m   = m + MU_BIAS;
        seg = 3'b000;
        for (int b = 6; b < 13; b++) begin
            if (m[b]) seg = 3'(b - 5);
        end
        return ~{neg, seg, 4'(m >> ({1'b0, seg} + 4'h1))};
    endfunction : tgb_mu

    function automatic logic [7:0] tgb_alaw(input logic signed [14:0] s);
        logic       neg;
        logic [13:0] m;
        logic [2:0] seg;
        neg = s[14];
        m   = neg ? 14'(-s) : 14'(s);
        m   = m >> 1;
        seg = 3'b000;
        for (int b = 5; b < 12; b++) begin
            if (m[b]) seg = 3'(b - 4);
        end
        return {~neg, seg, (seg == 3'b000) ? m[4:1] : 4'(m >> seg)} ^ A_XOR;
    endfunction : tgb_alaw

    tgb_fifo #(
        .W     ($bits(tgb_smp_s)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (q.busy),
        .in_ready  (fin_ready),
        .in_data   (smp),
        .out_valid (fout_valid),
        .out_ready (fout_ready),
        .out_data  (fout_data)
    );

    assign reg_rdata = q.rdata;
    assign dm_valid  = q.dm_v;
    assign dm_word   = q.dm;

    always_comb begin
        d        = q;
        en       = q.ctrl[CB_EN];
        alaw     = q.ctrl[CB_ALAW];
        sil      = alaw ? SIL_A : SIL_MU;
        start    = (q.frame == '0);
        push     = q.busy && fin_ready;
        pi       = 3'(q.idx - ADDR_PROG);
        ring_top = q.ctrl[CB_RATE] ? RING_HALF_FAST : RING_HALF_SLOW;
        // Fixed coefficients are constants, never register-backed
        if (q.idx < ADDR_FIXED) begin
            clo = DTMF_ROW[q.idx[3:2]];
            chi = DTMF_COL[q.idx[1:0]];
        end else if (q.idx < ADDR_PROG) begin
            clo = FIX_LO[4'(q.idx - ADDR_FIXED)];
            chi = FIX_HI[4'(q.idx - ADDR_FIXED)];
        end else begin
            clo = q.lo[pi];
            chi = q.hi[pi];
        end
        // Twisted levels; full scale is avoided so channel gain can add 3 dB
        amp_lo = alaw ? AMP_LO_A : AMP_LO_MU;
        amp_hi = alaw ? AMP_HI_A : AMP_HI_MU;
        p_lo   = tgb_sin(q.phase[{q.idx, 1'b0}]) * signed'({1'b0, amp_lo});
        p_hi   = tgb_sin(q.phase[{q.idx, 1'b1}]) * signed'({1'b0, amp_hi});
        if (clo == 8'h00) p_lo = '0;
        if (chi == 8'h00) p_hi = '0;
        acc    = 25'(p_lo) + 25'(p_hi);
        lin    = acc[24:10];
        // Ringers sit on programmable locations one and two, never on DTMF pairs
        ring_on = (q.idx == ADDR_PROG || q.idx == ADDR_PROG + 5'h01)
                  && q.ctrl[CB_RING1 + int'(pi[0])];
        crg    = q.ring_sel ? chi : clo;
        half   = 8'(({1'b0, crg} + 9'h001) >> 1);
        if (ring_on) begin
            // Squarewave of period coef+1 frames
            lin = (q.ring_cnt[pi[0]] < half) ? 15'(amp_hi)
                                                  : -15'(amp_hi);
        end
        smp.addr = q.idx;
        smp.code = alaw ? tgb_alaw(lin) : tgb_mu(lin);
        if (ring_on && crg == 8'h00) smp.code = sil;
        if (!ring_on && clo == 8'h00 && chi == 8'h00) smp.code = sil;
        if (q.idx == ADDR_LAST && q.ctrl[CB_FSK]) smp.code = fsk_sample;
        if (!en) smp.code = sil;

        d.frame = (q.frame == FRAME_LAST) ? '0 : q.frame + 1'b1;
        if (start) begin
            if (q.busy) begin
                d.overrun = 1'b1;
            end else begin
                d.busy = 1'b1;
                d.idx  = '0;
            end
            if (q.ring_div == ring_top) begin
                d.ring_div = '0;
                d.ring_sel = ~q.ring_sel;
            end else begin
                d.ring_div = q.ring_div + 1'b1;
            end
        end
        if (push) begin
            d.idx = q.idx + 1'b1;
            if (q.idx == ADDR_LAST) d.busy = 1'b0;
            if (en) begin
                d.phase[{q.idx, 1'b0}] = q.phase[{q.idx, 1'b0}] + tgb_inc(clo);
                d.phase[{q.idx, 1'b1}] = q.phase[{q.idx, 1'b1}] + tgb_inc(chi);
                if (ring_on) begin
                    d.ring_cnt[pi[0]] = (q.ring_cnt[pi[0]] >= crg) ? 8'h00
                                      : q.ring_cnt[pi[0]] + 8'h01;
                end
            end
        end
        // Disabled generator restarts every tone from phase zero
        if (!en) begin
            d.phase    = '0;
            d.ring_cnt = '0;
            d.ring_div = '0;
            d.ring_sel = 1'b0;
        end

        fout_ready = !q.dm_v || dm_ready;
        if (fout_ready) begin
            d.dm_v = fout_valid;
            if (fout_valid) d.dm = fout_data;
        end

        d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                d.rdata = q.ctrl;
            end else if (reg_addr == REG_STAT) begin
                d.rdata = {5'h00, ~fin_ready, q.overrun, q.busy};
            end else if (reg_addr >= REG_LOW && reg_addr < REG_LOW + 6'(N_PROG)) begin
                d.rdata = q.lo[3'(reg_addr - REG_LOW)];
            end else if (reg_addr >= REG_HIGH && reg_addr < REG_HIGH + 6'(N_PROG)) begin
                d.rdata = q.hi[3'(reg_addr - REG_HIGH)];
            end
        end
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                d.ctrl = reg_wdata;
            end else if (reg_addr == REG_STAT && reg_wdata[SB_OVR]) begin
                // A frame start that overruns a busy scan in the same cycle keeps the flag
                d.overrun = start && q.busy;
            end else if (reg_addr >= REG_LOW && reg_addr < REG_LOW + 6'(N_PROG)) begin
                d.lo[3'(reg_addr - REG_LOW)] = reg_wdata;
            end else if (reg_addr >= REG_HIGH && reg_addr < REG_HIGH + 6'(N_PROG)) begin
                d.hi[3'(reg_addr - REG_HIGH)] = reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_silent_off;
        push && !en |-> smp.code == sil;
    endproperty
    a_silent_off: assert property (p_silent_off) else $error("Tone not silent while off");

    property p_scan_end;
        push && q.idx == ADDR_LAST |=> !q.busy;
    endproperty
    a_scan_end: assert property (p_scan_end) else $error("Scan did not end after last");

    property p_zero_coef;
        push && en && q.idx >= ADDR_PROG && q.lo[pi] == 8'h00 && q.hi[pi] == 8'h00
            && q.idx != ADDR_LAST |-> smp.code == sil;
    endproperty
    a_zero_coef: assert property (p_zero_coef) else $error("Zero coefficients not silent");

    property p_fsk_sub;
        push && en && q.idx == ADDR_LAST && q.ctrl[CB_FSK] |-> smp.code == fsk_sample;
    endproperty
    a_fsk_sub: assert property (p_fsk_sub) else $error("FSK not substituted");

    property p_coef_wr;
        reg_wr && reg_addr == REG_LOW + 6'h02 |=> q.lo[2] == $past(reg_wdata);
    endproperty
    a_coef_wr: assert property (p_coef_wr) else $error("Coefficient write lost");

    property p_phase_hold;
        !en ##1 !en |-> q.phase == '0;
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("Phase moved while off");

    // Scan length is not bounded here: a stalled data memory may hold it past a frame
    property p_frame_go;
        start && !q.busy |=> q.busy && q.idx == 5'h00;
    endproperty
    a_frame_go: assert property (p_frame_go) else $error("Frame scan not started");

    property p_push_step;
        push |=> q.idx == $past(q.idx) + 5'h01;
    endproperty
    a_push_step: assert property (p_push_step) else $error("Scan skipped a location");

    // Row 697 Hz: coefficient 89 in the middle range, 89 x 64 phase units a frame
    property p_dtmf_step;
        push && en && q.idx == 5'h00 |=> q.phase[0] == $past(q.phase[0]) + 16'h1640;
    endproperty
    a_dtmf_step: assert property (p_dtmf_step) else $error("Low group step wrong");

    property p_ring_flip;
        en && start && q.ring_div == ring_top && !(reg_wr && reg_addr == REG_CTRL)
            |=> q.ring_sel != $past(q.ring_sel);
    endproperty
    a_ring_flip: assert property (p_ring_flip) else $error("Ringer did not alternate");

    property p_dm_hold;
        dm_valid && !dm_ready |=> dm_valid && $stable(dm_word);
    endproperty
    a_dm_hold: assert property (p_dm_hold) else $error("Data memory word dropped");

endmodule : tgb_tone_bank

// >>> bench/tgb_dm_model.sv
`timescale 1ns/1ps

module tgb_dm_model
    import tgb_pkg::*;
(
    input  wire logic       clk,       // System clock
    input  wire logic       srst,      // Sync reset
    input  wire logic       stall,     // Hold off data memory writes
    input  wire logic       dm_valid,  // Write request
    output logic            dm_ready,  // Write accept
    input  wire tgb_smp_s   dm_word,   // Address and code
    output logic            acc,       // Word taken at last edge
    output tgb_smp_s        acc_word,  // Word taken
    input  wire logic [4:0] conn_addr, // Connect memory low word
    output logic [7:0]      conn_code  // Sample seen by that channel
);
    logic [7:0] page [32];

    // Ready is registered, so a stall lands one cycle late, as real memory would
    always_ff @(posedge clk) begin
        if (srst) begin
            dm_ready <= 1'b0;
            acc      <= 1'b0;
            acc_word <= '0;
        end else begin
            dm_ready <= !stall;
            acc      <= dm_valid && dm_ready;
            acc_word <= dm_word;
            if (dm_valid && dm_ready) begin
                page[dm_word.addr] <= dm_word.code;
            end
        end
    end

    assign conn_code = page[conn_addr];
endmodule : tgb_dm_model

// >>> bench/test_tone_generator_bank.sv
`timescale 1ns/1ps

module test_tone_generator_bank
    import tgb_pkg::*;
;
    logic       clk;
    logic       srst;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] fsk_sample;
    logic       dm_valid;
    logic       dm_ready;
    tgb_smp_s   dm_word;
    tgb_smp_s   acc_word;
    logic       acc;
    logic       stall_all;
    logic       rnd_stall;
    logic       rnd_on;
    logic       chk_on;
    logic [4:0] conn_addr;
    logic [7:0] conn_code;
    logic [4:0] exp_addr;
    logic [7:0] m_ctrl;
    logic [7:0] sil;
    logic [7:0] lo_v [N_PROG];
    logic [7:0] hi_v [N_PROG];
    int         err_count;
    int         num_checks;
    int         frames;
    int         n_live;
    int         seed;

    tgb_tone_bank i_tgb_tone_bank (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fsk_sample(fsk_sample), .dm_valid(dm_valid), .dm_ready(dm_ready),
        .dm_word(dm_word)
    );

    tgb_dm_model i_tgb_dm_model (
        .clk(clk), .srst(srst), .stall(stall_all | rnd_stall), .dm_valid(dm_valid),
        .dm_ready(dm_ready), .dm_word(dm_word), .acc(acc), .acc_word(acc_word),
        .conn_addr(conn_addr), .conn_code(conn_code)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic fail(input string name, input logic [7:0] e, input logic [7:0] g);
        err_count++;
        $display("[ERR] %s expected %h seen %h", name, e, g);
    endtask : fail

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) fail(name, e, g);
    endtask : chk

    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic read_chk(input string name, input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(name, e, reg_rdata);
    endtask : read_chk

    task automatic wait_frames(input int n);
        int target;
        int guard;
        target = frames + n;
        guard  = 0;
        while (frames < target && guard < n * 6000) begin
            @(posedge clk);
            guard++;
        end
        if (frames < target) fail("frame_wait", 8'h00, 8'h01);
    endtask : wait_frames

    // Old words drain from the FIFO for a while, so model switches after two scans
    task automatic set_mode(input logic [7:0] c);
        chk_on = 1'b0;
        reg_write(REG_CTRL, c);
        read_chk("ctrl", REG_CTRL, c);
        wait_frames(2);
        m_ctrl = c;
        chk_on = 1'b1;
        wait_frames(2);
    endtask : set_mode

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        rnd_stall <= rnd_on ? (($random(seed) & 1) != 0) : 1'b0;
        if (srst) begin
            exp_addr = '0;
            frames   = 0;
            n_live   = 0;
        end
        if (acc) begin
            chk("addr", {3'b000, exp_addr}, {3'b000, acc_word.addr});
            exp_addr = exp_addr + 5'h01;
            sil = m_ctrl[CB_ALAW] ? SIL_A : SIL_MU;
            if (chk_on) begin
                if (!m_ctrl[CB_EN]) begin
                    chk("silence", sil, acc_word.code);
                end else if (acc_word.addr == ADDR_PROG && !m_ctrl[CB_RING1]) begin
                    chk("zero_coef", sil, acc_word.code);
                end else if (acc_word.addr == ADDR_LAST && m_ctrl[CB_FSK]) begin
                    chk("fsk", fsk_sample, acc_word.code);
                end else if (acc_word.addr == ADDR_PROG + 5'h01 && m_ctrl[CB_RING2]) begin
                    num_checks++;
                    if (acc_word.code === sil) fail("ringer", ~sil, acc_word.code);
                end else if (acc_word.addr < ADDR_FIXED && acc_word.code !== sil) begin
                    n_live++;
                end
            end
            if (acc_word.addr == ADDR_LAST) frames++;
        end
    end

    initial begin
        srst       = 1'b1;
        reg_addr   = '0;
        reg_wdata  = '0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        fsk_sample = 8'h00;
        conn_addr  = '0;
        stall_all  = 1'b0;
        rnd_on     = 1'b0;
        chk_on     = 1'b0;
        m_ctrl     = CTRL_RST;
        err_count  = 0;
        num_checks = 0;
        seed       = 41018;
        repeat (2) @(posedge clk);
        srst       <= 1'b0;
        fsk_sample <= 8'($random(seed));
        read_chk("ctrl_reset", REG_CTRL, CTRL_RST);
        reg_write(6'h17, 8'h5A);
        read_chk("beyond_prog", 6'h17, 8'h00);
        read_chk("unmapped", 6'h3F, 8'h00);
        for (int i = 0; i < N_PROG; i++) begin
            lo_v[i] = 8'($random(seed));
            hi_v[i] = 8'($random(seed));
            reg_write(REG_LOW + 6'(i), lo_v[i]);
            reg_write(REG_HIGH + 6'(i), hi_v[i]);
        end
        for (int i = 0; i < N_PROG; i++) begin
            read_chk("low_coef", REG_LOW + 6'(i), lo_v[i]);
            read_chk("high_coef", REG_HIGH + 6'(i), hi_v[i]);
        end
        reg_write(REG_LOW, 8'h00);
        reg_write(REG_HIGH, 8'h00);
        reg_write(REG_LOW + 6'h01, 8'h2A);
        reg_write(REG_HIGH + 6'h01, 8'h9F);
        reg_write(REG_LOW + 6'h02, 8'h00);
        set_mode(8'h00);
        set_mode(8'h30);
        conn_addr <= ADDR_LAST;
        @(posedge clk);
        #1 chk("connect", SIL_A, conn_code);
        set_mode(8'h2F);
        set_mode(8'h35);
        rnd_on = 1'b1;
        wait_frames(2);
        rnd_on = 1'b0;
        // Stall past two frame starts: one to start a stuck scan, one to overrun
        stall_all <= 1'b1;
        repeat (5200) @(posedge clk);
        read_chk("status_stalled", REG_STAT, 8'h07);
        reg_write(REG_STAT, 8'h02);
        read_chk("status_cleared", REG_STAT, 8'h05);
        stall_all <= 1'b0;
        wait_frames(3);
        chk("dtmf_live", 8'h01, {7'h00, n_live > 0});
        final_report();
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule : test_tone_generator_bank
